// ===== core/crf_consts.svh
// Purpose: Offsets, field positions, reset values and limits of the crypto status / RF config bank
// Assumes: Register index times four is the Wishbone byte address
// Notes:   Macros only; no logic here
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define CRF_IDX_CRYPTO_STAT   8'h2c
`define CRF_IDX_CHAN_FREQ     8'h2e
`define CRF_IDX_XTAL_TRIM     8'h2f
`define CRF_IDX_AMP_POWER     8'h30
`define CRF_IDX_IRQ_STAT      8'h40
`define CRF_IDX_IRQ_EN        8'h41
`define CRF_IDX_IRQ_CLR       8'h42

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CRF_RST_CHAN_FREQ     7'h0b
`define CRF_RST_XTAL_TRIM     4'hf
`define CRF_RST_AMP_POWER     8'h06

// ----------------------------------------------------------------
// Channel frequency mapping
// ----------------------------------------------------------------
`define CRF_FREQ_BASE_MHZ     12'h95a
`define CRF_FREQ_MAX_WORD     7'h71
`define CRF_FREQ_TOP_MHZ      12'h9cb

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CRF_PRIO_HIGH         1
`define CRF_PRIO_LOW          0

`endif

// ===== core/crf_pkg.sv
// Purpose: State types of the crypto status / RF config bank
// Assumes: Widths fixed at the documented values
// Notes:   Index 1 of each pair is the high-priority queue, index 0 the low one
package crf_pkg;

    // ----------------------------------------------------------------
    // Crypto status tracker state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] cryptoBusy;
        logic [1:0] authResult;
        logic [1:0] instrDone;
    } crf_stat_t;

    // ----------------------------------------------------------------
    // Register bank state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        ack;
        logic [7:0]  rdData;
        logic [6:0]  chanWord;
        logic [3:0]  oscTrimField;
        logic [7:0]  ampPowerCode;
        logic [1:0]  irqStat;
        logic [1:0]  irqEn;
        logic        irq;
        logic [11:0] freqMhz;
    } crf_regs_t;

endpackage

// ===== core/crf_crypto_if.sv
// Purpose: Carries crypto unit status from the tracker to the register bank
// Assumes: All signals are flops in the tracker
// Notes:   done is a one-cycle pulse per finished instruction
`timescale 1ns/1ps
interface crf_crypto_if;
    logic [1:0] busy;
    logic [1:0] authResult;
    logic [1:0] done;

    modport src (output busy, output authResult, output done);
    modport snk (input busy, input authResult, input done);
endinterface

// ===== core/crf_crypto_stat.sv
// Purpose: Tracks busy flags and authentication results of both crypto queues
// Assumes: Start and done strobes are one-cycle pulses from the crypto unit
// Notes:   A start in the same cycle as a done keeps the queue busy
`timescale 1ns/1ps
module crf_crypto_stat (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    input  wire logic [1:0] instrStart,
    input  wire logic [1:0] instrDone,
    input  wire logic [1:0] instrVerify,
    input  wire logic [1:0] authPass,
    crf_crypto_if.src       stat
);
    import crf_pkg::*;

    crf_stat_t st_ff;
    crf_stat_t nxt_st;

    // ----------------------------------------------------------------
    // Per-queue next state
    // ----------------------------------------------------------------
    genvar q;
    generate
        for (q = 0; q < 2; q++) begin : g_queue
            always_comb begin
                nxt_st.cryptoBusy[q] = instrStart[q]
                                     | (st_ff.cryptoBusy[q] & ~instrDone[q]);
                nxt_st.instrDone[q]  = instrDone[q];
                // A pass reports 1; an instruction without a check keeps the last result
                if (instrDone[q] && instrVerify[q]) begin
                    nxt_st.authResult[q] = authPass[q];
                end else begin
                    nxt_st.authResult[q] = st_ff.authResult[q];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

    assign stat.busy       = st_ff.cryptoBusy;
    assign stat.authResult = st_ff.authResult;
    assign stat.done       = st_ff.instrDone;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_auth_high;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && instrDone[1] && instrVerify[1]) |=> stat.authResult[1] == $past(authPass[1]);
    endproperty
    a_auth_high: assert property (p_auth_high) else $error("High auth result not taken");

    property p_auth_low;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && instrDone[0] && instrVerify[0]) |=> stat.authResult[0] == $past(authPass[0]);
    endproperty
    a_auth_low: assert property (p_auth_low) else $error("Low auth result not taken");

    property p_auth_fail;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && |(instrDone & instrVerify & ~authPass)) |=>
            ((stat.authResult & $past(instrDone & instrVerify & ~authPass)) == 2'h0);
    endproperty
    a_auth_fail: assert property (p_auth_fail) else $error("Failed check did not read 0");

    property p_auth_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (!(instrDone[1] && instrVerify[1]) && !(instrDone[0] && instrVerify[0]))
            |=> $stable(stat.authResult);
    endproperty
    a_auth_hold: assert property (p_auth_hold) else $error("Auth result moved");

    property p_busy_high;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && instrStart[1]) |=> stat.busy[1];
    endproperty
    a_busy_high: assert property (p_busy_high) else $error("High busy not set by start");

    property p_busy_low;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && instrDone[0] && !instrStart[0]) |=> !stat.busy[0];
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("Low busy not cleared by done");

endmodule // crf_crypto_stat

// ===== core/crf_regs.sv
// Purpose: Wishbone register bank for crypto status and RF channel, trim and power settings
// Assumes: Classic Wishbone, 32-bit data, byte address = register index * 4
// Notes:   Ack one cycle after the request; unmapped addresses ack and read zero
`timescale 1ns/1ps
`include "crf_consts.svh"

// How it works
// - High-priority verify end updates bit 3
// - Low-priority verify end updates bit 2
// - Failed check reads 0, passed check 1
// - Bit 1 high while high queue busy
// - Bit 0 high while low queue busy
// - Frequency is 2394 MHz plus channel word
// - Words 0 to 113 map linearly
// - Words 114 to 127 give 2507 MHz
// - Trim all ones untuned, lower adds load
module crf_regs (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [1:0]  instrStart,
    input  wire logic [1:0]  instrDone,
    input  wire logic [1:0]  instrVerify,
    input  wire logic [1:0]  authPass,
    output logic      [6:0]  chanWord,
    output logic      [11:0] rfFreqMhz,
    output logic      [3:0]  oscTrimField,
    output logic      [7:0]  ampPowerCode,
    output logic             irq
);
    import crf_pkg::*;

    localparam crf_regs_t REGS_RST = '{
        ack:          1'b0,
        rdData:       8'h00,
        chanWord:     `CRF_RST_CHAN_FREQ,
        oscTrimField: `CRF_RST_XTAL_TRIM,
        ampPowerCode: `CRF_RST_AMP_POWER,
        irqStat:      2'h0,
        irqEn:        2'h0,
        irq:          1'b0,
        freqMhz:      `CRF_FREQ_BASE_MHZ + {5'h00, `CRF_RST_CHAN_FREQ}
    };

    crf_regs_t   st_ff;
    crf_regs_t   nxt_st;
    logic [7:0]  regIdx;
    logic        busHit;

    crf_crypto_if cryptoLink ();

    // ----------------------------------------------------------------
    // Crypto queue tracker
    // ----------------------------------------------------------------
    crf_crypto_stat u_stat (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .clkEn       (clkEn),
        .instrStart  (instrStart),
        .instrDone   (instrDone),
        .instrVerify (instrVerify),
        .authPass    (authPass),
        .stat        (cryptoLink.src)
    );

    assign regIdx = wb_adr_i[9:2];
    // Third request term holds off a re-ack while the master drops its strobe
    assign busHit = wb_cyc_i & wb_stb_i & ~st_ff.ack;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] irqClr;
        logic [6:0] chanClamped;
        irqClr      = 2'h0;
        chanClamped = 7'h00;
        nxt_st        = st_ff;
        nxt_st.ack    = busHit;
        nxt_st.rdData = 8'h00;

        if (busHit && !wb_we_i) begin
            unique case (regIdx)
                `CRF_IDX_CRYPTO_STAT: begin
                    nxt_st.rdData = {4'h0, cryptoLink.authResult, cryptoLink.busy};
                end
                `CRF_IDX_CHAN_FREQ:  nxt_st.rdData = {1'b0, st_ff.chanWord};
                `CRF_IDX_XTAL_TRIM:  nxt_st.rdData = {4'h0, st_ff.oscTrimField};
                `CRF_IDX_AMP_POWER:  nxt_st.rdData = st_ff.ampPowerCode;
                `CRF_IDX_IRQ_STAT:   nxt_st.rdData = {6'h00, st_ff.irqStat};
                `CRF_IDX_IRQ_EN:     nxt_st.rdData = {6'h00, st_ff.irqEn};
                default:             nxt_st.rdData = 8'h00;
            endcase
        end

        // Only the low byte lane carries register data
        if (busHit && wb_we_i && wb_sel_i[0]) begin
            unique case (regIdx)
                `CRF_IDX_CHAN_FREQ:  nxt_st.chanWord     = wb_dat_i[6:0];
                `CRF_IDX_XTAL_TRIM:  nxt_st.oscTrimField = wb_dat_i[3:0];
                `CRF_IDX_AMP_POWER:  nxt_st.ampPowerCode = wb_dat_i[7:0];
                `CRF_IDX_IRQ_EN:     nxt_st.irqEn        = wb_dat_i[1:0];
                `CRF_IDX_IRQ_CLR:    irqClr              = wb_dat_i[1:0];
                default: ;
            endcase
        end

        // A finish in the same cycle as its clear is kept
        nxt_st.irqStat = (st_ff.irqStat & ~irqClr) | cryptoLink.done;
        nxt_st.irq     = |(nxt_st.irqStat & nxt_st.irqEn);

        // Out-of-band words clamp to the top of the band
        if (nxt_st.chanWord > `CRF_FREQ_MAX_WORD) begin
            chanClamped = `CRF_FREQ_MAX_WORD;
        end else begin
            chanClamped = nxt_st.chanWord;
        end
        nxt_st.freqMhz = `CRF_FREQ_BASE_MHZ + {5'h00, chanClamped};
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= REGS_RST;
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack_o     = st_ff.ack;
    assign wb_dat_o     = {24'h000000, st_ff.rdData};
    assign chanWord     = st_ff.chanWord;
    assign rfFreqMhz    = st_ff.freqMhz;
    assign oscTrimField = st_ff.oscTrimField;
    assign ampPowerCode = st_ff.ampPowerCode;
    assign irq          = st_ff.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_chan_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && wb_we_i && wb_sel_i[0] && regIdx == `CRF_IDX_CHAN_FREQ)
            |=> chanWord == $past(wb_dat_i[6:0])
                ##1 (chanWord == $past(wb_dat_i[6:0], 2) || wb_ack_o);
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("Channel word not written");

    property p_freq_linear;
        @(posedge clk_sys) disable iff (sys_rst)
        (chanWord <= `CRF_FREQ_MAX_WORD) |-> rfFreqMhz == `CRF_FREQ_BASE_MHZ + {5'h00, chanWord};
    endproperty
    a_freq_linear: assert property (p_freq_linear) else $error("In-band frequency wrong");

    property p_freq_clamp;
        @(posedge clk_sys) disable iff (sys_rst)
        (chanWord > `CRF_FREQ_MAX_WORD) |-> rfFreqMhz == `CRF_FREQ_TOP_MHZ;
    endproperty
    a_freq_clamp: assert property (p_freq_clamp) else $error("Word not clamped");

    property p_trim_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && wb_we_i && wb_sel_i[0] && regIdx == `CRF_IDX_XTAL_TRIM)
            |=> oscTrimField == $past(wb_dat_i[3:0]);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("Trim field not written");

    property p_ro_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && wb_we_i && regIdx == `CRF_IDX_CRYPTO_STAT)
            |=> $stable(chanWord) && $stable(oscTrimField) && $stable(ampPowerCode);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("Status write took effect");

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && !wb_we_i && regIdx == `CRF_IDX_CHAN_FREQ)
            |=> wb_ack_o && wb_dat_o[31:7] == 25'h0000000 && wb_dat_o[6:0] == chanWord;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Channel read wrong");

    property p_stat_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && !wb_we_i && regIdx == `CRF_IDX_CRYPTO_STAT)
            |=> wb_dat_o[3:0] == $past({cryptoLink.authResult, cryptoLink.busy})
                && wb_dat_o[31:4] == 28'h0000000;
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("Status readback wrong");

    property p_irq_level;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && |cryptoLink.done) |=> (irq == |(st_ff.irqStat & st_ff.irqEn)) && |st_ff.irqStat;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt not raised on finish");

    property p_ack_pulse;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && wb_ack_o) |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held for two cycles");

    property p_ack_answer;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit) |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("Request not answered");

    property p_low_busy_set;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && instrStart[0]) |=> cryptoLink.busy[0];
    endproperty
    a_low_busy_set: assert property (p_low_busy_set) else $error("Low busy not set");

    property p_high_busy_clear;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && instrDone[1] && !instrStart[1]) |=> !cryptoLink.busy[1];
    endproperty
    a_high_busy_clear: assert property (p_high_busy_clear) else $error("High busy stuck");

    property p_trim_readback;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && !wb_we_i && regIdx == `CRF_IDX_XTAL_TRIM)
            |=> wb_dat_o[31:4] == 28'h0000000 && wb_dat_o[3:0] == oscTrimField;
    endproperty
    a_trim_readback: assert property (p_trim_readback) else $error("Trim read wrong");

    property p_power_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && wb_we_i && wb_sel_i[0] && regIdx == `CRF_IDX_AMP_POWER)
            |=> ampPowerCode == $past(wb_dat_i[7:0]);
    endproperty
    a_power_write: assert property (p_power_write) else $error("Power code not written");

    property p_power_readback;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && !wb_we_i && regIdx == `CRF_IDX_AMP_POWER)
            |=> wb_dat_o == {24'h000000, ampPowerCode};
    endproperty
    a_power_readback: assert property (p_power_readback) else $error("Power read wrong");

    // A write with the low lane off must leave every setting alone
    property p_lane_off;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && wb_we_i && !wb_sel_i[0])
            |=> $stable(chanWord) && $stable(oscTrimField) && $stable(ampPowerCode)
                && $stable(st_ff.irqEn);
    endproperty
    a_lane_off: assert property (p_lane_off) else $error("Write without lane took effect");

    property p_unmapped_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && !wb_we_i
            && !(regIdx inside {`CRF_IDX_CRYPTO_STAT, `CRF_IDX_CHAN_FREQ, `CRF_IDX_XTAL_TRIM,
                                `CRF_IDX_AMP_POWER, `CRF_IDX_IRQ_STAT, `CRF_IDX_IRQ_EN}))
            |=> wb_dat_o == 32'h00000000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped not zero");

    property p_irq_stat_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && !wb_we_i && regIdx == `CRF_IDX_IRQ_STAT)
            |=> wb_dat_o == {30'h0, $past(st_ff.irqStat)};
    endproperty
    a_irq_stat_read: assert property (p_irq_stat_read) else $error("Interrupt status read wrong");

    // The set of a finishing instruction outranks a clear in the same cycle
    property p_irq_set_wins;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && |cryptoLink.done)
            |=> (st_ff.irqStat & $past(cryptoLink.done)) == $past(cryptoLink.done);
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins) else $error("Finish lost to clear");

    property p_irq_clear;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && wb_we_i && wb_sel_i[0] && regIdx == `CRF_IDX_IRQ_CLR
            && cryptoLink.done == 2'h0) |=> (st_ff.irqStat & $past(wb_dat_i[1:0])) == 2'h0;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("Clear did not clear");

    // Clock enable low holds every bit of state, the bus answer included
    property p_freeze;
        @(posedge clk_sys) disable iff (sys_rst)
        !clkEn |=> $stable(st_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved while frozen");

    property p_write_no_data;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkEn && busHit && wb_we_i) |=> wb_dat_o == 32'h00000000;
    endproperty
    a_write_no_data: assert property (p_write_no_data) else $error("Write returned data");

endmodule // crf_regs

// ===== dv/test_crf_regs.sv
// Purpose: Self-checking bench for the crypto status / RF config register bank
// Assumes: Classic Wishbone master, one request at a time, clkEn held high except in the freeze test
// Notes:   Each scenario is its own task; only mismatches and the verdict are printed
`timescale 1ns/1ps
`include "crf_consts.svh"
module test_crf_regs;
    logic        clk_sys;
    logic        sys_rst;
    logic        clkEn;
    logic        cyc, stb, we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] datW, datR;
    logic        ack;
    logic [1:0]  instrStart, instrDone, instrVerify, authPass;
    logic [6:0]  chanWord;
    logic [11:0] rfFreqMhz;
    logic [3:0]  oscTrimField;
    logic [7:0]  ampPowerCode;
    logic        irq;
    int          failCount   = 0;
    int          totalChecks = 0;

    crf_regs u_crf_regs (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .instrStart(instrStart),
        .instrDone(instrDone), .instrVerify(instrVerify), .authPass(authPass),
        .chanWord(chanWord), .rfFreqMhz(rfFreqMhz), .oscTrimField(oscTrimField),
        .ampPowerCode(ampPowerCode), .irq(irq));

    // ----------------------------------------------------------------
    // Clock, reset, watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        #(20000 * 50);
        failCount++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until ack is sampled high; gives up after 20 cycles and counts a failure
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] s, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        sel  <= s;
        datW <= {24'h000000, wd};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) failCount++;
        rd = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        bus(1'b1, idx, v, 4'hf, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, 4'hf, d);
        chk(d, {24'h000000, exp});
    endtask

    task automatic crypto(input int p, input bit st, input bit dn, input bit vf, input bit ps);
        @(posedge clk_sys);
        instrStart[p]  <= st;
        instrDone[p]   <= dn;
        instrVerify[p] <= vf;
        authPass[p]    <= ps;
        @(posedge clk_sys);
        {instrStart, instrDone, instrVerify, authPass} <= 8'h00;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        rdchk(`CRF_IDX_CRYPTO_STAT, 8'h00);
        rdchk(`CRF_IDX_CHAN_FREQ, 8'h0b);
        rdchk(`CRF_IDX_XTAL_TRIM, 8'h0f);
        rdchk(`CRF_IDX_AMP_POWER, 8'h06);
        chk({20'h0, rfFreqMhz}, 32'd2405);
    endtask

    // Boundary words on both sides of the band edge
    task automatic test_freq();
        logic [6:0] w [5] = '{7'h00, 7'h01, 7'h71, 7'h72, 7'h7f};
        foreach (w[i]) begin
            wr(`CRF_IDX_CHAN_FREQ, {1'b1, w[i]});
            rdchk(`CRF_IDX_CHAN_FREQ, {1'b0, w[i]});
            chk({25'h0, chanWord}, {25'h0, w[i]});
            chk({20'h0, rfFreqMhz}, (w[i] > 113) ? 32'd2507 : 32'd2394 + w[i]);
        end
        // Only the sixteen standard channels, 5 MHz apart from 2405 MHz
        for (int ch = 11; ch <= 26; ch++) begin
            wr(`CRF_IDX_CHAN_FREQ, 8'(11 + 5 * (ch - 11)));
            chk({20'h0, rfFreqMhz}, 32'(2405 + 5 * (ch - 11)));
        end
    endtask

    task automatic test_trim_power();
        wr(`CRF_IDX_XTAL_TRIM, 8'ha5);
        rdchk(`CRF_IDX_XTAL_TRIM, 8'h05);
        chk({28'h0, oscTrimField}, 32'h5);
        wr(`CRF_IDX_AMP_POWER, 8'hff);
        rdchk(`CRF_IDX_AMP_POWER, 8'hff);
        begin : nosel
            logic [31:0] d;
            bus(1'b1, `CRF_IDX_AMP_POWER, 8'h12, 4'he, d);
        end
        rdchk(`CRF_IDX_AMP_POWER, 8'hff);
        chk({24'h0, ampPowerCode}, 32'hff);
    endtask

    task automatic test_status();
        wr(`CRF_IDX_CRYPTO_STAT, 8'hff);
        rdchk(`CRF_IDX_CRYPTO_STAT, 8'h00);
        for (int p = 0; p < 2; p++) begin
            crypto(p, 1, 0, 0, 0);
            rdchk(`CRF_IDX_CRYPTO_STAT, 8'h01 << p);
            crypto(p, 0, 1, 1, 1);
            rdchk(`CRF_IDX_CRYPTO_STAT, 8'h04 << p);
            crypto(p, 1, 0, 0, 0);
            crypto(p, 0, 1, 1, 0);
            rdchk(`CRF_IDX_CRYPTO_STAT, 8'h00);
            crypto(p, 1, 1, 0, 1);
            rdchk(`CRF_IDX_CRYPTO_STAT, 8'h01 << p);
            crypto(p, 0, 1, 0, 1);
            rdchk(`CRF_IDX_CRYPTO_STAT, 8'h00);
        end
    endtask

    // Both queues finished above, so both sticky bits are set
    task automatic test_irq();
        chk({31'h0, irq}, 32'h0);
        rdchk(`CRF_IDX_IRQ_STAT, 8'h03);
        wr(`CRF_IDX_IRQ_EN, 8'h02);
        rdchk(`CRF_IDX_IRQ_EN, 8'h02);
        chk({31'h0, irq}, 32'h1);
        wr(`CRF_IDX_IRQ_CLR, 8'h02);
        rdchk(`CRF_IDX_IRQ_STAT, 8'h01);
        chk({31'h0, irq}, 32'h0);
        wr(`CRF_IDX_IRQ_CLR, 8'h01);
        rdchk(`CRF_IDX_IRQ_STAT, 8'h00);
    endtask

    task automatic test_unmapped();
        wr(8'h3c, 8'h5a);
        rdchk(8'h3c, 8'h00);
    endtask

    // A start seen while frozen is lost; a reset in mid-run restores every setting
    task automatic test_freeze_reset();
        @(posedge clk_sys);
        clkEn <= 1'b0;
        crypto(0, 1, 0, 0, 0);
        @(posedge clk_sys);
        clkEn <= 1'b1;
        rdchk(`CRF_IDX_CRYPTO_STAT, 8'h00);
        wr(`CRF_IDX_IRQ_EN, 8'h01);
        crypto(0, 1, 1, 0, 1);
        rdchk(`CRF_IDX_IRQ_STAT, 8'h01);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdchk(`CRF_IDX_CRYPTO_STAT, 8'h00);
        rdchk(`CRF_IDX_CHAN_FREQ, 8'h0b);
        rdchk(`CRF_IDX_XTAL_TRIM, 8'h0f);
        rdchk(`CRF_IDX_AMP_POWER, 8'h06);
        rdchk(`CRF_IDX_IRQ_EN, 8'h00);
        rdchk(`CRF_IDX_IRQ_STAT, 8'h00);
        chk({31'h0, irq}, 32'h0);
        chk({20'h0, rfFreqMhz}, 32'd2405);
    endtask

    task automatic tally_and_finish();
        if (failCount == 0 && totalChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        {cyc, stb, we} = 3'b000;
        adr  = 10'h000;
        sel  = 4'h0;
        datW = 32'h00000000;
        {instrStart, instrDone, instrVerify, authPass} = 8'h00;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        test_reset();
        test_freq();
        test_trim_power();
        test_status();
        test_irq();
        test_unmapped();
        test_freeze_reset();
        tally_and_finish();
    end
endmodule // test_crf_regs
